// ---- rtl/dim_pkg.sv ----
package dim_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int AD_W   = 12;
   localparam int DIG_W  = 4;
   localparam int WORD_W = 16;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CAPTURE_ENABLE_ADDR = 20'h1ae14;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR     = 20'h1ae20;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR       = 20'h1ae24;
   localparam logic [ADDR_W-1:0] ERROR_CODE_ADDR     = 20'h1ae28;
   localparam logic [ADDR_W-1:0] BOARD_INFO_ADDR     = 20'h1ae2c;

   // ----------------------------------------------------------------
   // Fields, codes and reset values
   // ----------------------------------------------------------------
   localparam int ENABLE_BIT     = 0;
   localparam int EVT_W          = 3;
   localparam int EVT_REJECT     = 0;
   localparam int EVT_UNMAPPED   = 1;
   localparam int EVT_MODE_CHG   = 2;
   localparam int INFO_OPT_BIT   = 0;
   localparam int INFO_CH_LSB    = 8;
   localparam int INFO_DLY_LSB   = 16;
   localparam int INFO_FIELD_W   = 8;
   localparam int ERR_W          = 16;

   localparam logic [ERR_W-1:0]  ERR_NONE_CODE    = 16'h0000;
   localparam logic [ERR_W-1:0]  ERR_FEATURE_CODE = 16'h0102;
   localparam logic              ENABLE_RESET     = 1'h0;
   localparam logic [EVT_W-1:0]  STATUS_RESET     = 3'h0;
   localparam logic [EVT_W-1:0]  MASK_RESET       = 3'h0;
   localparam logic [DATA_W-1:0] RDATA_IDLE       = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Board defaults
   // ----------------------------------------------------------------
   localparam int NUM_CH_DEFAULT    = 2;
   localparam int DIG_DELAY_DEFAULT = 2;

endpackage

// ---- rtl/dig_delay_line.sv ----
`timescale 1ns/1ps
module dig_delay_line #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             mclk_i,
   input  wire logic             rst_b_i,
   // Stream
   input  wire logic             adv_i,
   input  wire logic [WIDTH-1:0] data_i,
   output logic      [WIDTH-1:0] data_o
);

   logic [WIDTH-1:0] stage [DEPTH];

   // ----------------------------------------------------------------
   // Stages advance per accepted sample, so the offset counts samples
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_stage
         always_ff @(posedge mclk_i) begin
            if (!rst_b_i) begin
               stage[g] <= '0;
            end else if (adv_i) begin
               stage[g] <= (g == 0) ? data_i : stage[(g == 0) ? 0 : g-1];
            end
         end
      end
   endgenerate

   assign data_o = stage[DEPTH-1];

endmodule // dig_delay_line

// ---- rtl/sample_word_merge.sv ----
`timescale 1ns/1ps
module sample_word_merge #(
   parameter int NUM_CH = dim_pkg::NUM_CH_DEFAULT
) (
   // Mode
   input  wire logic                               dig_mode_i,
   // Channel data
   input  wire logic [NUM_CH*dim_pkg::AD_W-1:0]    analog_i,
   input  wire logic [NUM_CH*dim_pkg::DIG_W-1:0]   nibble_i,
   output logic      [NUM_CH*dim_pkg::WORD_W-1:0]  word_o
);

   localparam int AD_W  = dim_pkg::AD_W;
   localparam int DIG_W = dim_pkg::DIG_W;
   localparam int WW    = dim_pkg::WORD_W;

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_ch
         logic [AD_W-1:0]  res;
         logic [DIG_W-1:0] upper;
         assign res   = analog_i[c*AD_W +: AD_W];
         assign upper = dig_mode_i ? nibble_i[c*DIG_W +: DIG_W]
                                   : {DIG_W{res[AD_W-1]}};
         assign word_o[c*WW +: WW] = {upper, res};
      end
   endgenerate

endmodule // sample_word_merge

// ---- rtl/digital_input_sample_merge.sv ----
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module digital_input_sample_merge #(
   parameter int NUM_CH    = dim_pkg::NUM_CH_DEFAULT,
   parameter int DIG_DELAY = dim_pkg::DIG_DELAY_DEFAULT
) (
   // Clock, reset, enable
   input  wire logic                                mclk_i,
   input  wire logic                                rst_b_i,
   input  wire logic                                ce_i,
   // Board strap
   input  wire logic                                option_fitted_i,
   // Sample input
   input  wire logic                                sample_valid_i,
   input  wire logic [NUM_CH*dim_pkg::AD_W-1:0]     analog_channel_result_i,
   input  wire logic [NUM_CH*dim_pkg::DIG_W-1:0]    channel_digital_nibble_i,
   // Sample output
   output logic                                     sample_valid_o,
   output logic      [NUM_CH*dim_pkg::WORD_W-1:0]   sample_word_o,
   // Register port
   input  wire logic [dim_pkg::ADDR_W-1:0]          addr_i,
   input  wire logic [dim_pkg::DATA_W-1:0]          wdata_i,
   input  wire logic                                wr_i,
   input  wire logic                                rd_i,
   output logic      [dim_pkg::DATA_W-1:0]          rdata_o,
   // Interrupt
   output logic                                     irq_o
);

   localparam int AD_W   = dim_pkg::AD_W;
   localparam int DIG_W  = dim_pkg::DIG_W;
   localparam int WW     = dim_pkg::WORD_W;
   localparam int DATA_W = dim_pkg::DATA_W;
   localparam int EVT_W  = dim_pkg::EVT_W;
   localparam int IFW    = dim_pkg::INFO_FIELD_W;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic                      option_q;
   logic                      capture_enable;
   logic                      dig_mode;
   logic                      dig_mode_d;
   logic [EVT_W-1:0]          irq_status;
   logic [EVT_W-1:0]          irq_mask;
   logic [dim_pkg::ERR_W-1:0] error_code;
   logic [EVT_W-1:0]          evt;
   logic                      hit_en;
   logic                      hit_stat;
   logic                      hit_mask;
   logic                      hit_err;
   logic                      hit_info;
   logic                      mapped;
   logic                      reject;
   logic                      adv;
   logic [NUM_CH*DIG_W-1:0]   nibble_dly;
   logic [NUM_CH*WW-1:0]      next_word;
   logic [DATA_W-1:0]         next_rdata;
   logic [DATA_W-1:0]         info_word;

   // ----------------------------------------------------------------
   // Option strap
   // ----------------------------------------------------------------
   // Caught after reset release so that reset itself loads a constant.
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         option_q <= 1'b0;
      end else if (ce_i) begin
         option_q <= option_fitted_i;
      end
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   assign hit_en   = (addr_i == dim_pkg::CAPTURE_ENABLE_ADDR);
   assign hit_stat = (addr_i == dim_pkg::IRQ_STATUS_ADDR);
   assign hit_mask = (addr_i == dim_pkg::IRQ_MASK_ADDR);
   assign hit_err  = (addr_i == dim_pkg::ERROR_CODE_ADDR);
   assign hit_info = (addr_i == dim_pkg::BOARD_INFO_ADDR);
   assign mapped   = hit_en | hit_stat | hit_mask | hit_err | hit_info;

   // Asking for digital capture on a board without the option.
   assign reject = ce_i & wr_i & hit_en & wdata_i[dim_pkg::ENABLE_BIT] & ~option_q;

   // ----------------------------------------------------------------
   // Capture enable
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         capture_enable <= dim_pkg::ENABLE_RESET;
      end else if (ce_i && wr_i && hit_en && !reject) begin
         capture_enable <= wdata_i[dim_pkg::ENABLE_BIT];
      end else if (ce_i && !option_q) begin
         capture_enable <= 1'b0;
      end
   end

   // Stored enable is only honoured with the option present.
   assign dig_mode = capture_enable & option_q;

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         dig_mode_d <= 1'b0;
      end else if (ce_i) begin
         dig_mode_d <= dig_mode;
      end
   end

   // ----------------------------------------------------------------
   // Error code
   // ----------------------------------------------------------------
   // A fresh rejection in the cycle of a clear still leaves the code.
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         error_code <= dim_pkg::ERR_NONE_CODE;
      end else if (reject) begin
         error_code <= dim_pkg::ERR_FEATURE_CODE;
      end else if (ce_i && wr_i && hit_err) begin
         error_code <= dim_pkg::ERR_NONE_CODE;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   always_comb begin
      evt                        = '0;
      evt[dim_pkg::EVT_REJECT]   = reject;
      evt[dim_pkg::EVT_UNMAPPED] = ce_i & (wr_i | rd_i) & ~mapped;
      evt[dim_pkg::EVT_MODE_CHG] = ce_i & (dig_mode != dig_mode_d);
   end

   // Set wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         irq_status <= dim_pkg::STATUS_RESET;
      end else if (ce_i) begin
         irq_status <= (irq_status & ~((wr_i && hit_stat) ? wdata_i[EVT_W-1:0] : '0)) | evt;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         irq_mask <= dim_pkg::MASK_RESET;
      end else if (ce_i && wr_i && hit_mask) begin
         irq_mask <= wdata_i[EVT_W-1:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= |(irq_status & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      info_word                                 = '0;
      info_word[dim_pkg::INFO_OPT_BIT]          = option_q;
      info_word[dim_pkg::INFO_CH_LSB +: IFW]    = IFW'(NUM_CH);
      info_word[dim_pkg::INFO_DLY_LSB +: IFW]   = IFW'(DIG_DELAY);
   end

   always_comb begin
      next_rdata = dim_pkg::RDATA_IDLE;
      if (rd_i) begin
         if (hit_en) begin
            next_rdata[dim_pkg::ENABLE_BIT] = capture_enable;
         end else if (hit_stat) begin
            next_rdata[EVT_W-1:0] = irq_status;
         end else if (hit_mask) begin
            next_rdata[EVT_W-1:0] = irq_mask;
         end else if (hit_err) begin
            next_rdata[dim_pkg::ERR_W-1:0] = error_code;
         end else if (hit_info) begin
            next_rdata = info_word;
         end
      end
   end

   // Read data stand for one clock-enabled cycle after the strobe and hold while ce_i is low.
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         rdata_o <= dim_pkg::RDATA_IDLE;
      end else if (ce_i) begin
         rdata_o <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Sample path
   // ----------------------------------------------------------------
   // The pipeline moves only on accepted samples, so the offset stays
   // a fixed number of samples whatever the sample rate.
   assign adv = ce_i & sample_valid_i;

   dig_delay_line #(
      .WIDTH (NUM_CH*DIG_W),
      .DEPTH (DIG_DELAY)
   ) u_dly (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .adv_i   (adv),
      .data_i  (channel_digital_nibble_i),
      .data_o  (nibble_dly)
   );

   sample_word_merge #(
      .NUM_CH (NUM_CH)
   ) u_merge (
      .dig_mode_i (dig_mode),
      .analog_i   (analog_channel_result_i),
      .nibble_i   (nibble_dly),
      .word_o     (next_word)
   );

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         sample_word_o <= '0;
      end else if (adv) begin
         sample_word_o <= next_word;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         sample_valid_o <= 1'b0;
      end else if (ce_i) begin
         sample_valid_o <= sample_valid_i;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_valid_follows: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && sample_valid_i) |=> sample_valid_o)
      else $error("sample valid did not follow input");

   a_low_result_kept: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      adv |=> sample_word_o[AD_W-1:0] == $past(analog_channel_result_i[AD_W-1:0]))
      else $error("converter result not in low bits");

   a_std_sign_ext: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (adv && !dig_mode) |=>
         sample_word_o[WW-1:AD_W] == {DIG_W{$past(analog_channel_result_i[AD_W-1])}})
      else $error("upper bits are not a sign extension");

   a_dig_nibble_in: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (adv && dig_mode) |=> sample_word_o[WW-1:AD_W] == $past(nibble_dly[DIG_W-1:0]))
      else $error("upper bits do not carry digital nibble");

   a_enable_readback: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && rd_i && hit_en) |=>
         rdata_o == {{(DATA_W-1){1'b0}}, $past(capture_enable)})
      else $error("capture enable read back wrong");

   a_enable_store: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && wr_i && hit_en && option_q) |=>
         capture_enable == $past(wdata_i[dim_pkg::ENABLE_BIT]))
      else $error("capture enable not stored");

   a_no_option_std: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (adv && !option_q) |=>
         sample_word_o[WW-1:AD_W] == {DIG_W{sample_word_o[AD_W-1]}})
      else $error("format changed without option");

   a_feature_reject: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      reject |=> (error_code == dim_pkg::ERR_FEATURE_CODE) && !capture_enable
                 && irq_status[dim_pkg::EVT_REJECT])
      else $error("absent option not rejected");

   a_delay_reset: assert property (
      @(posedge mclk_i)
      !rst_b_i |=> nibble_dly == '0)
      else $error("delay pipeline not cleared");

   a_delay_hold: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      !adv |=> $stable(nibble_dly) && $stable(sample_word_o))
      else $error("sample path moved without a sample");

   a_irq_level: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && |(irq_status & irq_mask)) |=> irq_o)
      else $error("interrupt not raised");

   a_unmapped_zero: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && rd_i && !mapped) |=> rdata_o == dim_pkg::RDATA_IDLE
                                    && irq_status[dim_pkg::EVT_UNMAPPED])
      else $error("unmapped read not answered with zero");

   a_valid_low: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && !sample_valid_i) |=> !sample_valid_o)
      else $error("sample valid raised without a sample");

   // A dropped clock enable must freeze the enable, status, mask, error, read data, interrupt and sample output registers
   a_freeze_state: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      !ce_i |=> $stable(capture_enable) && $stable(irq_status) && $stable(irq_mask)
                && $stable(error_code) && $stable(rdata_o) && $stable(irq_o)
                && $stable(sample_valid_o) && $stable(sample_word_o))
      else $error("state moved while clock enable low");

   a_rdata_idle: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && !rd_i) |=> rdata_o == dim_pkg::RDATA_IDLE)
      else $error("read data stood without a read");

   a_mask_store: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && wr_i && hit_mask) |=> irq_mask == $past(wdata_i[EVT_W-1:0]))
      else $error("interrupt mask not stored");

   a_error_clear: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && wr_i && hit_err) |=> error_code == dim_pkg::ERR_NONE_CODE)
      else $error("error code not cleared by write");

   a_irq_low: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && !(|(irq_status & irq_mask))) |=> !irq_o)
      else $error("interrupt raised with nothing pending");

   a_mode_event: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && (dig_mode != dig_mode_d)) |=> irq_status[dim_pkg::EVT_MODE_CHG])
      else $error("mode change not flagged");

   // Written ones clear their bits unless the same event fires again
   a_status_clear: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && wr_i && hit_stat) |=>
         (irq_status & $past(wdata_i[EVT_W-1:0]) & ~$past(evt)) == '0)
      else $error("status bits not cleared by write");

endmodule // digital_input_sample_merge

// ---- dv/adc_source_model.sv ----
`timescale 1ns/1ps
module adc_source_model #(
   parameter int NUM_CH = dim_pkg::NUM_CH_DEFAULT
) (
   // Clock and control
   input  wire logic                              mclk_i,
   input  wire logic                              run_i,
   // Converter results and digital lines
   output logic                                   sample_valid_o,
   output logic      [NUM_CH*dim_pkg::AD_W-1:0]   analog_o,
   output logic      [NUM_CH*dim_pkg::DIG_W-1:0]  nibble_o
);
   // ----------------------------------------------------------------
   // Conversion source
   // ----------------------------------------------------------------
   int          seed = 32'h2045;
   logic [63:0] rnd;

   initial begin
      sample_valid_o = 1'b0;
      analog_o       = '0;
      nibble_o       = '0;
   end

   // Analog and digital lines take new values on every clock edge, strobed or not
   always @(posedge mclk_i) begin
      rnd = {$random(seed), $random(seed)};
      if (run_i) begin
         sample_valid_o <= rnd[63:62] != 2'h0;
         analog_o       <= rnd[NUM_CH*dim_pkg::AD_W-1:0];
         nibble_o       <= rnd[32+:NUM_CH*dim_pkg::DIG_W];
      end else begin
         // Idle lines do not keep their value, so stale data cannot pass
         sample_valid_o <= 1'b0;
         analog_o       <= ~analog_o;
         nibble_o       <= ~nibble_o;
      end
   end
endmodule // adc_source_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
   // ----------------------------------------------------------------
   // Setup
   // ----------------------------------------------------------------
   localparam int NUM_CH    = 2;
   localparam int DIG_DELAY = 3;
   localparam int WW        = NUM_CH*dim_pkg::WORD_W;

   logic                          mclk_i          = 1'b0;
   logic                          rst_b_i         = 1'b0;
   logic                          ce_i            = 1'b1;
   logic                          option_fitted_i = 1'b1;
   logic                          run             = 1'b0;
   logic                          chk_on          = 1'b0;
   logic                          exp_mode        = 1'b0;
   logic                          exp_v;
   logic [WW-1:0]                 exp_word;
   logic                          sample_valid_i;
   logic [NUM_CH*12-1:0]          analog;
   logic [NUM_CH*4-1:0]           nibble;
   logic [NUM_CH*4-1:0]           nq[$];
   logic                          sample_valid_o;
   logic [WW-1:0]                 sample_word_o;
   logic [dim_pkg::ADDR_W-1:0]    addr_i          = '0;
   logic [dim_pkg::DATA_W-1:0]    wdata_i         = '0;
   logic                          wr_i            = 1'b0;
   logic                          rd_i            = 1'b0;
   logic [dim_pkg::DATA_W-1:0]    rdata_o;
   logic                          irq_o;
   int                            error_cnt       = 0;
   int                            check_count     = 0;
   int                            cyc             = 0;

   always #5 mclk_i = ~mclk_i;

   adc_source_model #(.NUM_CH(NUM_CH)) i_src (.mclk_i(mclk_i), .run_i(run),
      .sample_valid_o(sample_valid_i), .analog_o(analog), .nibble_o(nibble));

   digital_input_sample_merge #(.NUM_CH(NUM_CH), .DIG_DELAY(DIG_DELAY)) i_dut (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .option_fitted_i(option_fitted_i),
      .sample_valid_i(sample_valid_i), .analog_channel_result_i(analog),
      .channel_digital_nibble_i(nibble), .sample_valid_o(sample_valid_o),
      .sample_word_o(sample_word_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

   // ----------------------------------------------------------------
   // Reference model of the sample path
   // ----------------------------------------------------------------
   always @(posedge mclk_i) begin : model
      logic [NUM_CH*4-1:0] old;
      if (!rst_b_i) begin
         exp_v    = 1'b0;
         exp_word = '0;
         nq.delete();
         for (int i = 0; i < DIG_DELAY; i++) nq.push_back('0);
      end else if (ce_i) begin
         exp_v = sample_valid_i;
         if (sample_valid_i) begin
            // Delay counts accepted samples only
            nq.push_back(nibble);
            old = nq.pop_front();
            for (int c = 0; c < NUM_CH; c++) begin
               exp_word[c*16+:16] = {exp_mode ? old[c*4+:4] : {4{analog[c*12+11]}},
                                     analog[c*12+:12]};
            end
         end
      end
   end

   always @(posedge mclk_i) begin
      #1;
      if (chk_on) begin
         chk_flag("sample_valid_o", exp_v, sample_valid_o);
         chk_word("sample_word_o", exp_word, sample_word_o);
      end
   end

   // ----------------------------------------------------------------
   // Compare and bus tasks
   // ----------------------------------------------------------------
   task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_word(input string n, input logic [WW-1:0] e, input logic [WW-1:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_flag(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic reg_wr(input logic [19:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [19:0] a, input logic [31:0] e, input string n);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      #1;
      chk_reg(n, e, rdata_o);
   endtask

   // Random samples with the clock enable dropped every seventh cycle
   task automatic stream(input int n);
      @(posedge mclk_i);
      run    <= 1'b1;
      chk_on <= 1'b1;
      repeat (n) begin
         @(posedge mclk_i);
         cyc++;
         ce_i <= (cyc % 7) != 0;
      end
      run  <= 1'b0;
      ce_i <= 1'b1;
      repeat (DIG_DELAY + 3) @(posedge mclk_i);
      chk_on <= 1'b0;
   endtask

   task automatic final_report;
      if (error_cnt == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      reg_rd(dim_pkg::CAPTURE_ENABLE_ADDR, 32'h0, "enable");
      reg_rd(dim_pkg::IRQ_MASK_ADDR, 32'h0, "mask");
      reg_rd(dim_pkg::BOARD_INFO_ADDR, {8'h00, 8'(DIG_DELAY), 8'(NUM_CH), 8'h01}, "info");
      reg_rd(20'h1ae30, 32'h0, "unmapped");
      reg_rd(dim_pkg::IRQ_STATUS_ADDR, 32'h2, "status");
      reg_wr(dim_pkg::IRQ_STATUS_ADDR, 32'h2);
      reg_rd(dim_pkg::IRQ_STATUS_ADDR, 32'h0, "status");
      stream(60);
      // Reset after the first run: the digital delay line must restart from zero
      @(posedge mclk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      reg_wr(dim_pkg::CAPTURE_ENABLE_ADDR, 32'h1);
      repeat (2) @(posedge mclk_i);
      reg_rd(dim_pkg::CAPTURE_ENABLE_ADDR, 32'h1, "enable");
      reg_rd(dim_pkg::IRQ_STATUS_ADDR, 32'h4, "status");
      reg_wr(dim_pkg::IRQ_MASK_ADDR, 32'h4);
      @(posedge mclk_i);
      #1 chk_flag("irq_o", 1'b1, irq_o);
      reg_wr(dim_pkg::IRQ_STATUS_ADDR, 32'h4);
      @(posedge mclk_i);
      #1 chk_flag("irq_o", 1'b0, irq_o);
      exp_mode = 1'b1;
      stream(80);
      reg_wr(dim_pkg::CAPTURE_ENABLE_ADDR, 32'h0);
      repeat (2) @(posedge mclk_i);
      reg_wr(dim_pkg::IRQ_STATUS_ADDR, 32'h4);
      exp_mode = 1'b0;
      @(posedge mclk_i);
      option_fitted_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      reg_wr(dim_pkg::CAPTURE_ENABLE_ADDR, 32'h1);
      repeat (2) @(posedge mclk_i);
      reg_rd(dim_pkg::CAPTURE_ENABLE_ADDR, 32'h0, "enable");
      reg_rd(dim_pkg::ERROR_CODE_ADDR, 32'h102, "error");
      reg_rd(dim_pkg::IRQ_STATUS_ADDR, 32'h1, "status");
      chk_flag("irq_o", 1'b0, irq_o);
      reg_wr(dim_pkg::ERROR_CODE_ADDR, 32'h0);
      reg_rd(dim_pkg::ERROR_CODE_ADDR, 32'h0, "error");
      stream(40);
      final_report;
   end

   initial begin
      repeat (5000) @(posedge mclk_i);
      error_cnt++;
      final_report;
   end
endmodule // tb
